// *** sfpec_pkg.sv ***
// Purpose: Shared constants for the serial flash program/erase sequencer.
// Assumes: Core clock of 25 MHz; single-line opcodes, quad input data for 32h.
// Notes:   Times are in microseconds; cycle counts are derived in the module.
package sfpec_pkg;

    // Opcodes
    localparam logic [7:0] OP_WREN   = 8'h06;
    localparam logic [7:0] OP_WRDI   = 8'h04;
    localparam logic [7:0] OP_RDSR   = 8'h05;
    localparam logic [7:0] OP_QPROG  = 8'h32;
    localparam logic [7:0] OP_SE     = 8'h20;
    localparam logic [7:0] OP_BE32   = 8'h52;
    localparam logic [7:0] OP_BE64   = 8'hD8;
    localparam logic [7:0] OP_CE1    = 8'hC7;
    localparam logic [7:0] OP_CE2    = 8'h60;
    localparam logic [7:0] OP_SUSP   = 8'h75;
    localparam logic [7:0] OP_RESUME = 8'h7A;

    // Link clock counts (edges since chip select fell)
    localparam logic [5:0] CNT_OPC   = 6'h08;
    localparam logic [5:0] CNT_QADR  = 6'h0E;
    localparam logic [5:0] CNT_ADDR  = 6'h20;
    localparam logic [5:0] CNT_MAX   = 6'h3F;

    // Region masks of each erase unit and of a page
    localparam logic [23:0] PAGE_MASK   = 24'h00_00FF;
    localparam logic [23:0] SECTOR_MASK = 24'h00_0FFF;
    localparam logic [23:0] BLK32_MASK  = 24'h00_7FFF;
    localparam logic [23:0] BLK64_MASK  = 24'h00_FFFF;

    // Status byte bit positions
    localparam int STAT_BUSY = 0;
    localparam int STAT_WEL  = 1;
    localparam int STAT_SUS  = 7;

    // Timing
    localparam int unsigned CORE_CLK_MHZ  = 25;
    localparam int unsigned PROG_TIME_US  = 700;
    localparam int unsigned SE_TIME_US    = 45000;
    localparam int unsigned BE32_TIME_US  = 120000;
    localparam int unsigned BE64_TIME_US  = 150000;
    localparam int unsigned CE_TIME_US    = 10000000;
    localparam int unsigned SUSP_TIME_US  = 20;

    typedef enum logic [1:0] {
        SFPEC_IDLE      = 2'b00,
        SFPEC_RUN       = 2'b01,
        SFPEC_SUSP_WAIT = 2'b10,
        SFPEC_SUSPENDED = 2'b11
    } sfpec_state_e;

    typedef enum logic [2:0] {
        SFPEC_K_PROG = 3'b000,
        SFPEC_K_SE   = 3'b001,
        SFPEC_K_BE32 = 3'b010,
        SFPEC_K_BE64 = 3'b011,
        SFPEC_K_CE   = 3'b100
    } sfpec_kind_e;

endpackage : sfpec_pkg

// *** sfpec_core.sv ***
// Purpose: Program/erase/suspend command handling of a serial flash device.
// Assumes: Link clock idles between frames; chip select high for 8+ core cycles.
// Notes:   The memory array itself sits outside, behind the array port.
// What this block does
// - Quad page program runs only when the quad enable pin is 1.
// - Program frame: opcode 32h, 24-bit address and data, four bits per clock.
// - One program writes at most 256 bytes into erased locations.
// - Program and erase run only when the write enable latch is 1.
// - Opcode 20h with address erases the addressed 4K-byte sector.
// - Opcode 52h with address erases the addressed 32K-byte block.
// - Opcode D8h with address erases the addressed 64K-byte block.
// - Opcode C7h or 60h alone erases the whole array.
// - A frame not ending on a byte boundary is discarded.
// - Busy is 1 for the whole self-timed cycle, 0 afterwards.
// - Read status stays served while a cycle runs.
// - The write enable latch clears when an erase completes.
// - Protected targets are not erased; chip erase needs nothing protected.
// - Suspend 75h accepted only with suspend 0, busy 1, during erase or program.
// - Suspend during chip erase is ignored.
// - Suspend flag rises at once; busy falls within the suspend latency.
// - Reset releases a suspended operation and clears the suspend flag.
// - Resume 7Ah with suspend 1, busy 0 clears suspend and restarts quickly.
// - Program data past the page end wraps to the page start.
`timescale 1ns/1ps
`default_nettype none
module sfpec_core #(
    parameter int unsigned PROG_CYCLES = sfpec_pkg::CORE_CLK_MHZ * sfpec_pkg::PROG_TIME_US,
    parameter int unsigned SE_CYCLES   = sfpec_pkg::CORE_CLK_MHZ * sfpec_pkg::SE_TIME_US,
    parameter int unsigned BE32_CYCLES = sfpec_pkg::CORE_CLK_MHZ * sfpec_pkg::BE32_TIME_US,
    parameter int unsigned BE64_CYCLES = sfpec_pkg::CORE_CLK_MHZ * sfpec_pkg::BE64_TIME_US,
    parameter int unsigned CE_CYCLES   = sfpec_pkg::CORE_CLK_MHZ * sfpec_pkg::CE_TIME_US,
    parameter int unsigned SUSP_CYCLES = sfpec_pkg::CORE_CLK_MHZ * sfpec_pkg::SUSP_TIME_US
) (
    // Core clock and reset
    input  wire logic        core_clk_i,
    input  wire logic        resetn_i,
    // Serial link
    input  wire logic        link_clk_i,
    input  wire logic        cs_n_i,
    input  wire logic [3:0]  serial_line_i,
    output logic      [3:0]  serial_line_o,
    output logic      [3:0]  serial_line_oe_o,
    // Configuration pins
    input  wire logic        quad_io_enable_i,
    input  wire logic        prot_en_i,
    input  wire logic [23:0] prot_first_i,
    input  wire logic [23:0] prot_last_i,
    // Status
    output logic             busy_o,
    output logic             write_enable_latch_o,
    output logic             suspend_flag_o,
    // Array port
    output logic             array_wr_o,
    output logic             array_erase_o,
    output logic      [2:0]  array_erase_kind_o,
    output logic      [23:0] array_addr_o,
    output logic      [7:0]  array_wdata_o
);
    // ---------------- Link domain ----------------
    logic        lk_fresh;
    logic [5:0]  lk_cnt;
    logic [2:0]  lk_phase;
    logic [7:0]  lk_op;
    logic [23:0] lk_addr;
    logic        lk_half;
    logic        lk_any;
    logic [3:0]  lk_hinib;
    logic [7:0]  lk_wptr;
    logic        lk_tog;
    logic [255:0] lk_mask;
    logic [7:0]  lk_buf [256];
    logic [2:0]  lk_st1;
    logic [2:0]  lk_st2;
    wire [5:0] lk_cnt_inc  = (lk_cnt == sfpec_pkg::CNT_MAX) ? lk_cnt : lk_cnt + 6'h01;
    wire       lk_quad     = (lk_op == sfpec_pkg::OP_QPROG);
    wire       lk_locked   = lk_st2[0] | lk_st2[2];
    wire       lk_data     = !lk_fresh && lk_quad && (lk_cnt >= sfpec_pkg::CNT_QADR);
    wire       lk_wr_byte  = lk_data && lk_half && !lk_locked;
    // Page wrap comes from the 8-bit index overflowing
    wire [7:0] lk_widx     = lk_addr[7:0] + lk_wptr;
    wire       lk_clr_mask = !lk_fresh && lk_quad && (lk_cnt == sfpec_pkg::CNT_OPC) && !lk_locked;
    wire [7:0] lk_stat     = {lk_st2[2], 5'h00, lk_st2[1], lk_st2[0]};
    wire [2:0] lk_bit      = 3'h7 - lk_phase;
    // Set while chip select is high; the next link edge starts a new frame
    always_ff @(posedge link_clk_i or posedge cs_n_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lk_fresh <= 1'b1;
        end else if (cs_n_i) begin
            lk_fresh <= 1'b1;
        end else begin
            lk_fresh <= 1'b0;
        end
    end

    always_ff @(posedge link_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lk_st1 <= 3'h0;
            lk_st2 <= 3'h0;
        end else begin
            lk_st1 <= {suspend_flag_o, write_enable_latch_o, busy_o};
            lk_st2 <= lk_st1;
        end
    end

    always_ff @(posedge link_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lk_cnt   <= 6'h00;
            lk_phase <= 3'h0;
            lk_op    <= 8'h00;
            lk_addr  <= 24'h00_0000;
            lk_half  <= 1'b0;
            lk_any   <= 1'b0;
            lk_hinib <= 4'h0;
            lk_wptr  <= 8'h00;
            lk_tog   <= 1'b0;
        end else if (lk_fresh) begin
            lk_cnt   <= 6'h01;
            lk_phase <= 3'h1;
            lk_op    <= {7'h00, serial_line_i[0]};
            lk_addr  <= 24'h00_0000;
            lk_half  <= 1'b0;
            lk_any   <= 1'b0;
            lk_wptr  <= 8'h00;
            lk_tog   <= !lk_tog;
        end else begin
            lk_cnt   <= lk_cnt_inc;
            lk_phase <= lk_phase + 3'h1;
            if (lk_cnt < sfpec_pkg::CNT_OPC) begin
                lk_op <= {lk_op[6:0], serial_line_i[0]};
            end else if (lk_quad && lk_cnt < sfpec_pkg::CNT_QADR) begin
                lk_addr <= {lk_addr[19:0], serial_line_i};
            end else if (lk_quad) begin
                lk_half <= !lk_half;
                if (!lk_half) begin
                    lk_hinib <= serial_line_i;
                end else begin
                    lk_wptr <= lk_wptr + 8'h01;
                    lk_any  <= 1'b1;
                end
            end else if (lk_cnt < sfpec_pkg::CNT_ADDR) begin
                lk_addr <= {lk_addr[22:0], serial_line_i[0]};
            end
        end
    end
    // Buffer is frozen while busy or suspended so a running program keeps its data
    always_ff @(posedge link_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            lk_mask <= '0;
        end else if (lk_clr_mask) begin
            lk_mask <= '0;
        end else if (lk_wr_byte) begin
            lk_mask[lk_widx] <= 1'b1;
        end
    end
    always_ff @(posedge link_clk_i) begin
        if (lk_wr_byte) begin
            lk_buf[lk_widx] <= {lk_hinib, serial_line_i};
        end
    end
    // Status bits shift out on falling edges, repeating for continuous polling
    always_ff @(negedge link_clk_i or posedge cs_n_i or negedge resetn_i) begin
        if (!resetn_i) begin
            serial_line_o    <= 4'h0;
            serial_line_oe_o <= 4'h0;
        end else if (cs_n_i) begin
            serial_line_o    <= 4'h0;
            serial_line_oe_o <= 4'h0;
        end else if (!lk_fresh && lk_op == sfpec_pkg::OP_RDSR && lk_cnt >= sfpec_pkg::CNT_OPC) begin
            serial_line_o    <= {2'b00, lk_stat[lk_bit], 1'b0};
            serial_line_oe_o <= 4'h2;
        end else begin
            serial_line_o    <= 4'h0;
            serial_line_oe_o <= 4'h0;
        end
    end
    // ---------------- Core domain ----------------
    logic        c_cs1, c_cs2, c_cs3;
    logic        c_tg1, c_tg2, c_seen;
    logic [49:0] c_cfg1, c_cfg2;
    sfpec_pkg::sfpec_state_e st;
    sfpec_pkg::sfpec_kind_e  kind;
    logic [31:0] timer;
    logic [31:0] lat;
    logic [8:0]  ptr;
    logic [23:0] base;
    // Link registers are static once chip select is high; a new clock-less pulse is not a frame
    wire fe       = c_cs2 && !c_cs3 && (c_tg2 != c_seen);
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            c_cs1  <= 1'b1;
            c_cs2  <= 1'b1;
            c_cs3  <= 1'b1;
            c_tg1  <= 1'b0;
            c_tg2  <= 1'b0;
            c_seen <= 1'b0;
            c_cfg1 <= '0;
            c_cfg2 <= '0;
        end else begin
            c_cs1  <= cs_n_i;
            c_cs2  <= c_cs1;
            c_cs3  <= c_cs2;
            c_tg1  <= lk_tog;
            c_tg2  <= c_tg1;
            c_seen <= fe ? c_tg2 : c_seen;
            c_cfg1 <= {quad_io_enable_i, prot_en_i, prot_first_i, prot_last_i};
            c_cfg2 <= c_cfg1;
        end
    end
    wire        cfg_qe    = c_cfg2[49];
    wire        cfg_en    = c_cfg2[48];
    wire [23:0] cfg_first = c_cfg2[47:24];
    wire [23:0] cfg_last  = c_cfg2[23:0];
    wire f_short  = (lk_cnt == sfpec_pkg::CNT_OPC);
    wire f_addr   = (lk_cnt == sfpec_pkg::CNT_ADDR);
    wire quad_ok  = lk_any && !lk_half;
    wire is_se    = (lk_op == sfpec_pkg::OP_SE);
    wire is_b32   = (lk_op == sfpec_pkg::OP_BE32);
    wire is_b64   = (lk_op == sfpec_pkg::OP_BE64);
    wire is_ce    = (lk_op == sfpec_pkg::OP_CE1) || (lk_op == sfpec_pkg::OP_CE2);
    wire [23:0] u_mask = is_se  ? sfpec_pkg::SECTOR_MASK :
                         is_b32 ? sfpec_pkg::BLK32_MASK  :
                         is_b64 ? sfpec_pkg::BLK64_MASK  : sfpec_pkg::PAGE_MASK;
    wire [23:0] rg_lo  = lk_addr & ~u_mask;
    wire [23:0] rg_hi  = lk_addr | u_mask;
    wire        prot_hit = cfg_en && (rg_lo <= cfg_last) && (rg_hi >= cfg_first);
    wire idle      = (st == sfpec_pkg::SFPEC_IDLE);
    wire can_write = idle && write_enable_latch_o && !suspend_flag_o;
    wire go_prog   = fe && lk_quad && quad_ok && cfg_qe && can_write && !prot_hit;
    wire go_erase  = fe && f_addr && (is_se || is_b32 || is_b64) && can_write && !prot_hit;
    wire go_ce     = fe && f_short && is_ce && can_write && !cfg_en;
    wire go_susp   = fe && f_short && (lk_op == sfpec_pkg::OP_SUSP) && (st == sfpec_pkg::SFPEC_RUN)
                     && !suspend_flag_o && (kind != sfpec_pkg::SFPEC_K_CE);
    wire go_res    = fe && f_short && (lk_op == sfpec_pkg::OP_RESUME)
                     && (st == sfpec_pkg::SFPEC_SUSPENDED) && suspend_flag_o;
    wire wr_cmd    = fe && f_short && !busy_o;
    wire set_wel   = wr_cmd && (lk_op == sfpec_pkg::OP_WREN);
    wire clr_wel   = wr_cmd && (lk_op == sfpec_pkg::OP_WRDI);
    wire done      = (st == sfpec_pkg::SFPEC_RUN) && (timer == 32'h0000_0000) && !go_susp;
    wire sfpec_pkg::sfpec_kind_e e_kind = is_se  ? sfpec_pkg::SFPEC_K_SE   :
                                          is_b32 ? sfpec_pkg::SFPEC_K_BE32 :
                                          is_b64 ? sfpec_pkg::SFPEC_K_BE64 : sfpec_pkg::SFPEC_K_CE;
    wire [31:0] e_dur = is_se  ? SE_CYCLES[31:0]   :
                        is_b32 ? BE32_CYCLES[31:0] :
                        is_b64 ? BE64_CYCLES[31:0] : CE_CYCLES[31:0];
    wire prog_step = (kind == sfpec_pkg::SFPEC_K_PROG) && !ptr[8];
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            write_enable_latch_o <= 1'b0;
        end else if (done) begin
            write_enable_latch_o <= 1'b0;
        end else if (set_wel) begin
            write_enable_latch_o <= 1'b1;
        end else if (clr_wel) begin
            write_enable_latch_o <= 1'b0;
        end
    end
    // Reset is the power loss: it drops any suspended operation
    always_ff @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            st             <= sfpec_pkg::SFPEC_IDLE;
            suspend_flag_o <= 1'b0;
            busy_o         <= 1'b0;
            kind           <= sfpec_pkg::SFPEC_K_PROG;
            timer          <= 32'h0000_0000;
            lat            <= 32'h0000_0000;
            ptr            <= 9'h000;
            base           <= 24'h00_0000;
            array_wr_o     <= 1'b0;
            array_erase_o  <= 1'b0;
            array_erase_kind_o <= 3'h0;
            array_addr_o   <= 24'h00_0000;
            array_wdata_o  <= 8'h00;
        end else begin
            array_wr_o    <= 1'b0;
            array_erase_o <= 1'b0;
            case (st)
                sfpec_pkg::SFPEC_IDLE: begin
                    if (go_prog) begin
                        st     <= sfpec_pkg::SFPEC_RUN;
                        busy_o <= 1'b1;
                        kind   <= sfpec_pkg::SFPEC_K_PROG;
                        timer  <= PROG_CYCLES[31:0];
                        ptr    <= 9'h000;
                        base   <= rg_lo;
                    end else if (go_erase || go_ce) begin
                        st     <= sfpec_pkg::SFPEC_RUN;
                        busy_o <= 1'b1;
                        kind   <= e_kind;
                        timer  <= e_dur;
                        array_erase_o      <= 1'b1;
                        array_erase_kind_o <= e_kind;
                        array_addr_o       <= go_ce ? 24'h00_0000 : rg_lo;
                    end
                end
                sfpec_pkg::SFPEC_RUN: begin
                    if (go_susp) begin
                        st             <= sfpec_pkg::SFPEC_SUSP_WAIT;
                        suspend_flag_o <= 1'b1;
                        lat            <= SUSP_CYCLES[31:0];
                    end else if (done) begin
                        st     <= sfpec_pkg::SFPEC_IDLE;
                        busy_o <= 1'b0;
                    end else begin
                        timer <= timer - 32'h0000_0001;
                        if (prog_step) begin
                            ptr <= ptr + 9'h001;
                            array_wr_o    <= lk_mask[ptr[7:0]];
                            array_addr_o  <= {base[23:8], ptr[7:0]};
                            array_wdata_o <= lk_buf[ptr[7:0]];
                        end
                    end
                end
                sfpec_pkg::SFPEC_SUSP_WAIT: begin
                    if (lat == 32'h0000_0000) begin
                        st     <= sfpec_pkg::SFPEC_SUSPENDED;
                        busy_o <= 1'b0;
                    end else begin
                        lat <= lat - 32'h0000_0001;
                    end
                end
                sfpec_pkg::SFPEC_SUSPENDED: begin
                    if (go_res) begin
                        st             <= sfpec_pkg::SFPEC_RUN;
                        suspend_flag_o <= 1'b0;
                        busy_o         <= 1'b1;
                    end
                end
                default: begin
                    st <= sfpec_pkg::SFPEC_IDLE;
                end
            endcase
        end
    end
    // ---------------- Checks ----------------
    localparam int SuspBound = 1000;
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!resetn_i);
    busy_state_a: assert property (busy_o == (st == sfpec_pkg::SFPEC_RUN || st == sfpec_pkg::SFPEC_SUSP_WAIT))
        else $error("busy does not match the cycle state");
    qe_gate_a: assert property ((fe && lk_quad && !cfg_qe && idle) |=> idle)
        else $error("quad program started without quad enable");
    wel_gate_a: assert property ((fe && !write_enable_latch_o && idle) |=> idle)
        else $error("write started without write enable latch");
    frame_len_a: assert property ((fe && is_se && !f_addr && idle) |=> idle)
        else $error("misaligned erase frame executed");
    wel_clear_a: assert property ((done && kind != sfpec_pkg::SFPEC_K_PROG) |=> !write_enable_latch_o && !busy_o)
        else $error("erase end left latch or busy set");
    ce_protect_a: assert property ((fe && is_ce && cfg_en && idle) |=> idle && !array_erase_o)
        else $error("chip erase ran with protection on");
    ce_nosusp_a: assert property ((st == sfpec_pkg::SFPEC_RUN && kind == sfpec_pkg::SFPEC_K_CE)
        |=> !suspend_flag_o)
        else $error("chip erase was suspended");
    susp_lat_a: assert property ($rose(suspend_flag_o) |-> busy_o ##[1:SuspBound] !busy_o)
        else $error("busy not released after suspend");
    resume_busy_a: assert property ($fell(suspend_flag_o) |-> ##[0:4] busy_o)
        else $error("busy not raised after resume");
    prog_bytes_a: assert property (array_wr_o |-> array_addr_o[23:8] == base[23:8])
        else $error("program write left its page");
    prog_run_c: cover property (go_prog ##1 array_wr_o);
    erase_done_c: cover property (go_erase ##1 busy_o ##[1:SuspBound] done);
    susp_res_c: cover property (go_susp ##[1:SuspBound] go_res);

endmodule : sfpec_core
`default_nettype wire

// *** sfpec_host.sv ***
// Purpose: Host-side model driving program/erase frames into the flash sequencer.
// Assumes: Link clock idles low between frames; 80 ns link period inside frames.
// Notes:   Captures the status line on every rising edge for read-status frames.
`timescale 1ns/1ps
`default_nettype none
module sfpec_host (
    // Link towards the device
    output logic       link_clk_o,
    output logic       cs_n_o,
    output logic [3:0] line_o,
    // Device status output
    input  wire logic  status_line_i
);
    logic [31:0] rx;

    initial begin
        link_clk_o = 1'b0;
        cs_n_o     = 1'b1;
        line_o     = 4'h0;
        rx         = 32'h0000_0000;
    end

    // One link clock: data set while low, sampled by the device on the rise
    task automatic edge_out(input logic [3:0] v);
        line_o <= v;
        #20 link_clk_o <= 1'b1;
        rx <= {rx[30:0], status_line_i};
        #40 link_clk_o <= 1'b0;
        #20;
    endtask : edge_out

    // Single-line bits MSB first, then quad nibbles high first
    task automatic frame(input logic [31:0] s, input int ns, input logic [63:0] q, input int nq);
        #7 cs_n_o <= 1'b0;
        #40;
        for (int i = ns - 1; i >= 0; i--) edge_out({4{s[i]}});
        for (int i = nq - 1; i >= 0; i--) edge_out(q[4*i +: 4]);
        #20 cs_n_o <= 1'b1;
        // Released lines must not keep looking valid
        line_o <= ~line_o;
        // Gap above the minimum chip select high time
        #400;
    endtask : frame
endmodule : sfpec_host
`default_nettype wire

// *** tb_sfpec_core.sv ***
// Purpose: Self-checking bench for the program/erase/suspend sequencer.
// Assumes: Shortened cycle counts; host model makes the link clock.
// Notes:   Array pulses are counted by a monitor on the core clock.
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin cmp_count++; if ((a) !== (e)) begin fail_count++; \
    $display("mismatch %s exp %0h got %0h", n, e, a); end end
module tb_sfpec_core;
    localparam logic [7:0]  EOP [5] = '{8'h20, 8'h52, 8'hD8, 8'hC7, 8'h60};
    localparam logic [23:0] EMSK [5] = '{24'h00_0FFF, 24'h00_7FFF, 24'h00_FFFF, 24'hFF_FFFF, 24'hFF_FFFF};
    localparam logic [2:0]  EKND [5] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h4};
    logic        core_clk, resetn, qe, prot_en;
    logic [23:0] pf, pl, er_a, wr_a;
    logic [2:0]  er_k;
    logic [7:0]  wr_d;
    int          er_n, wr_n, fail_count, cmp_count;
    wire         link_clk, cs_n, busy, write_enable_latch, suspend_flag, awr, aer;
    wire [3:0]   host_line, dout, doe, line;
    wire [2:0]   akind;
    wire [23:0]  aaddr;
    wire [7:0]   awd;
    assign line = (doe & dout) | (~doe & host_line);

    sfpec_host i_sfpec_host (.link_clk_o(link_clk), .cs_n_o(cs_n), .line_o(host_line), .status_line_i(line[1]));
    sfpec_core #(.PROG_CYCLES(300), .SE_CYCLES(800), .BE32_CYCLES(60), .BE64_CYCLES(60),
        .CE_CYCLES(400)) i_sfpec_core (
        .core_clk_i(core_clk), .resetn_i(resetn), .link_clk_i(link_clk), .cs_n_i(cs_n),
        .serial_line_i(line), .serial_line_o(dout), .serial_line_oe_o(doe),
        .quad_io_enable_i(qe), .prot_en_i(prot_en), .prot_first_i(pf), .prot_last_i(pl),
        .busy_o(busy), .write_enable_latch_o(write_enable_latch), .suspend_flag_o(suspend_flag),
        .array_wr_o(awr), .array_erase_o(aer), .array_erase_kind_o(akind),
        .array_addr_o(aaddr), .array_wdata_o(awd));

    initial begin
        core_clk = 1'b0;
        forever #20 core_clk = ~core_clk;
    end

    always @(posedge core_clk) begin
        if (aer === 1'b1) begin
            er_n++; er_a = aaddr; er_k = akind;
        end
        // Keep the first write of a program: it shows where the wrapped byte landed
        if (awr === 1'b1 && wr_n == 0) begin
            wr_a = aaddr;
            wr_d = awd;
        end
        if (awr === 1'b1) begin
            wr_n++;
        end
    end

    task automatic final_report();
        if (fail_count == 0 && cmp_count > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report

    task automatic do_reset();
        @(posedge core_clk) resetn <= 1'b0;
        repeat (8) @(posedge core_clk);
        resetn <= 1'b1;
        repeat (4) @(posedge core_clk);
    endtask : do_reset

    task automatic cmd(input logic [7:0] op);
        i_sfpec_host.frame({24'h00_0000, op}, 8, 64'h0, 0);
    endtask : cmd

    task automatic wait_idle();
        for (int i = 0; i < 3000 && busy !== 1'b0; i++) @(posedge core_clk);
        `CHK("busy end", 1'b0, busy)
    endtask : wait_idle

    initial begin
        fail_count = 0; cmp_count = 0; er_n = 0; wr_n = 0;
        resetn = 1'b0; qe = 1'b0; prot_en = 1'b0; pf = 24'h01_0000; pl = 24'h01_0FFF;
        do_reset();
        cmd(8'h06);
        cmd(8'h04);
        `CHK("wel off", 1'b0, write_enable_latch)
        i_sfpec_host.frame({8'h20, 24'h00_1000}, 32, 64'h0, 0);
        cmd(8'h75);
        `CHK("erase no wel", 0, er_n)
        `CHK("idle suspend", 1'b0, suspend_flag)
        cmd(8'h06);
        `CHK("wel set", 1'b1, write_enable_latch)
        // Opcode stays aligned; only the last address bit is missing
        i_sfpec_host.frame({8'h20, 24'h00_1000} >> 1, 31, 64'h0, 0);
        `CHK("short frame", 0, er_n)
        @(posedge core_clk) prot_en <= 1'b1;
        i_sfpec_host.frame({8'h20, 24'h01_0800}, 32, 64'h0, 0);
        cmd(8'hC7);
        `CHK("protected", 0, er_n)
        @(posedge core_clk) prot_en <= 1'b0;
        for (int k = 0; k < 5; k++) begin
            cmd(8'h06);
            er_n = 0;
            if (k < 3) i_sfpec_host.frame({EOP[k], 24'h3A_5B7C}, 32, 64'h0, 0);
            else cmd(EOP[k]);
            `CHK("erase count", 1, er_n)
            `CHK("erase base", 24'h3A_5B7C & ~EMSK[k], er_a)
            `CHK("erase kind", EKND[k], er_k)
            `CHK("busy run", 1'b1, busy)
            wait_idle();
            `CHK("wel clear", 1'b0, write_enable_latch)
        end
        cmd(8'h06);
        i_sfpec_host.frame(32'h32, 8, 64'h0001_FEA1_B2C3, 12);
        `CHK("no quad", 0, wr_n)
        @(posedge core_clk) qe <= 1'b1;
        i_sfpec_host.frame(32'h32, 8, 64'h0001_FEA1_B2C3, 12);
        cmd(8'h75);
        `CHK("prog sus", 1'b1, suspend_flag)
        // Only resume is sent while the program is held
        repeat (510) @(posedge core_clk);
        `CHK("prog sus busy", 1'b0, busy)
        cmd(8'h7A);
        wait_idle();
        `CHK("write count", 3, wr_n)
        `CHK("wrap addr", 24'h00_0100, wr_a)
        `CHK("wrap data", 8'hC3, wr_d)
        cmd(8'h06);
        i_sfpec_host.frame({8'h20, 24'h00_2000}, 32, 64'h0, 0);
        i_sfpec_host.frame(32'h0500, 16, 64'h0, 0);
        `CHK("status busy", 8'h03, i_sfpec_host.rx[7:0])
        cmd(8'h75);
        `CHK("sus set", 1'b1, suspend_flag)
        // Only resume is sent while the erase is held
        repeat (510) @(posedge core_clk);
        `CHK("sus busy", 1'b0, busy)
        cmd(8'h7A);
        `CHK("resume sus", 1'b0, suspend_flag)
        `CHK("resume busy", 1'b1, busy)
        repeat (510) @(posedge core_clk);
        cmd(8'h75);
        `CHK("sus again", 1'b1, suspend_flag)
        do_reset();
        `CHK("reset sus", 1'b0, suspend_flag)
        cmd(8'h06);
        cmd(8'hC7);
        cmd(8'h75);
        `CHK("ce no sus", 1'b0, suspend_flag)
        `CHK("ce busy", 1'b1, busy)
        wait_idle();
        final_report();
    end

    initial begin
        #2_000_000;
        fail_count++;
        final_report();
    end
endmodule : tb_sfpec_core
`default_nettype wire
